//--- nibble_swap_xor_regs.vh
// constants for the nibble swap and xor datapath slice
`ifndef NIBBLE_SWAP_XOR_REGS_VH
`define NIBBLE_SWAP_XOR_REGS_VH
`define OP_NONE 2'h0
`define OP_NIBBLE_SWAP 2'h1
`define OP_XOR_ACC_FILE 2'h2
`define OP_XOR_LITERAL_ACC 2'h3
`define DEST_ACC 1'h0
`define DEST_FILE 1'h1
`define ACC_RESET 8'h00
`define ZERO_RESET 1'h0
`define ZERO_WE_RESET 1'h0
`define FILE_WE_RESET 1'h0
`define FILE_WDATA_RESET 8'h00
`define NIBBLE_W 4
`define BYTE_W 8
`endif

//--- nibble_swap_xor_ops.v
// datapath slice for nibble swap and the two xor operations
`include "nibble_swap_xor_regs.vh"

module nibble_swap_xor_ops #(
    parameter ADDR_W = 7
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // instruction from decode, one cycle each
    input wire op_valid,
    input wire [1:0] op_code,
    input wire dest_sel,
    input wire [ADDR_W-1:0] file_addr,
    input wire [7:0] literal,
    // file register read data for file_addr, same cycle
    input wire [7:0] file_rdata,
    // file register write port
    output reg file_we,
    output reg [ADDR_W-1:0] file_waddr,
    output reg [7:0] file_wdata,
    // core state
    output reg [7:0] acc,
    output reg zero_flag,
    output reg zero_we
);

////////////////////////////////////////////////////////////////////////
// decode helpers, shared by the write, flag and result paths
function op_match;
    input valid;
    input [1:0] code;
    input [1:0] want;
    begin
        op_match = valid & (code == want);
    end
endfunction

function to_file;
    input sel;
    begin
        to_file = (sel == `DEST_FILE);
    end
endfunction

function to_acc;
    input sel;
    begin
        to_acc = (sel == `DEST_ACC);
    end
endfunction

function all_zero;
    input [7:0] value;
    begin
        all_zero = (value == 8'h00);
    end
endfunction

////////////////////////////////////////////////////////////////////////
// one strobe per accepted op; op_code 0 or a low op_valid leaves all idle
// at most one strobe is high, each nonzero op_code picks exactly one form
// dest_sel means nothing to the literal form, which always lands in acc
wire do_swap;
wire do_xor_file;
wire do_xor_lit;
wire swap_to_acc;
wire swap_to_file;
wire xor_to_acc;
wire xor_to_file;

assign do_swap = op_match(op_valid, op_code, `OP_NIBBLE_SWAP);
assign do_xor_file = op_match(op_valid, op_code, `OP_XOR_ACC_FILE);
assign do_xor_lit = op_match(op_valid, op_code, `OP_XOR_LITERAL_ACC);
assign swap_to_acc = do_swap & to_acc(dest_sel);
assign swap_to_file = do_swap & to_file(dest_sel);
assign xor_to_acc = do_xor_file & to_acc(dest_sel);
assign xor_to_file = do_xor_file & to_file(dest_sel);

////////////////////////////////////////////////////////////////////////
// nibble exchange is pure wiring, one bit pair per pass
wire [7:0] swapped;

genvar bit_idx;
generate
    for (bit_idx = 0; bit_idx < `NIBBLE_W; bit_idx = bit_idx + 1) begin : g_swap
        assign swapped[bit_idx + `NIBBLE_W] = file_rdata[bit_idx];
        assign swapped[bit_idx] = file_rdata[bit_idx + `NIBBLE_W];
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// one operand mux serves both xor forms, so only one 8-bit xor is built
wire [7:0] xor_operand;
wire [7:0] xor_result;

assign xor_operand = do_xor_lit ? literal : file_rdata;

generate
    for (bit_idx = 0; bit_idx < `BYTE_W; bit_idx = bit_idx + 1) begin : g_xor
        assign xor_result[bit_idx] = acc[bit_idx] ^ xor_operand[bit_idx];
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// which state the accepted op touches
wire file_load;
wire zero_load;

assign file_load = swap_to_file | xor_to_file;
// swap leaves the zero flag alone, so only the two xor forms load it
assign zero_load = do_xor_file | do_xor_lit;

////////////////////////////////////////////////////////////////////////
// next values; the write port holds its last address and data between writes
reg [7:0] next_acc;
reg next_zero_flag;
reg next_zero_we;
reg next_file_we;
reg [ADDR_W-1:0] next_file_waddr;
reg [7:0] next_file_wdata;

always @* begin
    next_acc = acc;
    if (swap_to_acc) begin
        next_acc = swapped;
    end else if (xor_to_acc) begin
        next_acc = xor_result;
    end else if (do_xor_lit) begin
        next_acc = xor_result;
    end
end

always @* begin
    // flag holds through swaps and idle cycles
    next_zero_flag = zero_flag;
    if (zero_load) begin
        next_zero_flag = all_zero(xor_result);
    end
end

always @* begin
    next_zero_we = zero_load;
end

always @* begin
    next_file_we = file_load;
end

always @* begin
    next_file_waddr = file_waddr;
    if (file_load) begin
        next_file_waddr = file_addr;
    end
end

always @* begin
    next_file_wdata = file_wdata;
    if (swap_to_file) begin
        next_file_wdata = swapped;
    end else if (xor_to_file) begin
        next_file_wdata = xor_result;
    end
end

////////////////////////////////////////////////////////////////////////
// results land on the next edge; decode must not issue a read of a
// file register written by the previous op without its own bypass
// acc and zero flag are the core's own state
always @(posedge clk) begin
    if (!rstn) begin
        acc <= `ACC_RESET;
    end else begin
        acc <= next_acc;
    end
end

always @(posedge clk) begin
    if (!rstn) begin
        zero_flag <= `ZERO_RESET;
    end else begin
        zero_flag <= next_zero_flag;
    end
end

// write port address and data
always @(posedge clk) begin
    if (!rstn) begin
        file_waddr <= {ADDR_W{1'b0}};
    end else begin
        file_waddr <= next_file_waddr;
    end
end

always @(posedge clk) begin
    if (!rstn) begin
        file_wdata <= `FILE_WDATA_RESET;
    end else begin
        file_wdata <= next_file_wdata;
    end
end

////////////////////////////////////////////////////////////////////////
// one-cycle pulses for the core's status and file logic
always @(posedge clk) begin
    if (!rstn) begin
        zero_we <= `ZERO_WE_RESET;
    end else begin
        zero_we <= next_zero_we;
    end
end

always @(posedge clk) begin
    if (!rstn) begin
        file_we <= `FILE_WE_RESET;
    end else begin
        file_we <= next_file_we;
    end
end

endmodule

//--- nsx_chk_sva.sv
// assertions for the swap and xor slice
module nsx_chk #(parameter ADDR_W = 7) (input wire clk,rstn,op_valid,dest_sel,file_we,zero_flag,zero_we,
input wire [1:0] op_code,input wire [ADDR_W-1:0] file_addr,file_waddr,
input wire [7:0] literal,file_rdata,file_wdata,acc);
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
wire sw=op_valid&&op_code==2'h1, xf=op_valid&&op_code==2'h2, xl=op_valid&&op_code==2'h3;
a_swap_acc: assert property(sw&&!dest_sel|=>{acc[3:0],acc[7:4]}==$past(file_rdata)) else $error("swap");
a_swap_file: assert property(sw&&dest_sel|=>file_we&&{file_wdata[3:0],file_wdata[7:4]}==$past(file_rdata))
else $error("nibble_swap_op");
a_swap_flags: assert property(sw|=>!zero_we&&$stable(zero_flag)) else $error("swapz");
a_xor_acc: assert property(xf&&!dest_sel|=>acc==($past(acc)^$past(file_rdata))&&zero_we) else $error("xor");
a_xor_file: assert property(xf&&dest_sel|=>file_we&&file_wdata==($past(acc)^$past(file_rdata)))
else $error("xorf");
a_lit_xor: assert property(xl|=>acc==($past(acc)^$past(literal))&&zero_we&&!file_we) else $error("lit");
a_zero_value: assert property(zero_we|->zero_flag==((file_we?file_wdata:acc)==8'h00)) else $error("z");
a_write_addr: assert property((sw||xf)&&dest_sel|=>file_waddr==$past(file_addr)) else $error("addr");
a_idle_quiet: assert property(!(sw||xf||xl)|=>!file_we&&!zero_we&&$stable(acc)) else $error("idle");
cover property(sw&&dest_sel);
cover property(xf&&dest_sel);
cover property(zero_we&&zero_flag);
cover property(xl);
endmodule
bind nibble_swap_xor_ops nsx_chk #(.ADDR_W(ADDR_W)) i_chk(.clk(clk),.rstn(rstn),.op_valid(op_valid),
.dest_sel(dest_sel),.file_we(file_we),.zero_flag(zero_flag),.zero_we(zero_we),.op_code(op_code),
.file_addr(file_addr),.file_waddr(file_waddr),.literal(literal),.file_rdata(file_rdata),
.file_wdata(file_wdata),.acc(acc));

//--- tb.sv
// bench for the swap and xor slice
module tb;
timeunit 1ns;
timeprecision 1ns;
logic clk=0,rstn=0,v=0,d=0;
logic [1:0] c=0;
logic [6:0] a=0;
logic [7:0] r=0,k=0;
wire fw,zf,zw;
wire [6:0] wa;
wire [7:0] wd,acc;
int miscompares=0,checks_done=0,cyc=0;
nibble_swap_xor_ops i_dut(.clk,.rstn,.op_valid(v),.op_code(c),.dest_sel(d),.file_addr(a),.literal(k),
.file_rdata(r),.file_we(fw),.file_waddr(wa),.file_wdata(wd),.acc,.zero_flag(zf),.zero_we(zw));
initial forever #25 clk=~clk;
always @(posedge clk) if (++cyc>200) begin
miscompares++;
stop_test;
end
task chk(string n,logic [31:0] s,e);
checks_done++;
if (s!==e) begin
miscompares++;
$display("Error %s exp %h got %h",n,e,s);
end
endtask
// one idle cycle between ops keeps the pulses apart
task op(logic [1:0] o,logic dd,logic [6:0] aa,logic [7:0] rd,kk);
@(posedge clk); v<=1; c<=o; d<=dd; a<=aa; r<=rd; k<=kk;
@(posedge clk); v<=0;
#1;
endtask
task t_swap;
op(2'h1,0,7'h05,8'ha5,0); chk("sa",acc,8'h5a);
op(2'h1,1,7'h2a,8'h3c,0); chk("sf",{fw,zw,wa,wd},{2'b10,7'h2a,8'hc3});
chk("sk",acc,8'h5a);
endtask
task t_xor;
op(2'h2,0,7'h05,8'h5a,0); chk("xa",{acc,zf,zw},{8'h00,2'b11});
op(2'h1,0,7'h05,8'h12,0); chk("sz",{acc,zf,zw},{8'h21,2'b10});
op(2'h2,1,7'h7f,8'h0f,0); chk("xf",{fw,wd,acc,zf},{1'b1,8'h2e,8'h21,1'b0});
chk("xw",wa,7'h7f);
op(2'h2,1,7'h00,8'h21,0); chk("xz",{fw,zw,zf,wa,wd},{3'b111,7'h00,8'h00});
endtask
task t_lit;
op(2'h3,1,7'h05,0,8'h0f); chk("xl",{acc,fw,zw,zf},{8'h2e,3'b010});
op(2'h3,0,7'h05,0,8'hff); chk("l2",{acc,zf},{8'hd1,1'b0});
op(2'h3,0,7'h05,0,8'hd1); chk("lz",{acc,zf,zw},{8'h00,2'b11});
endtask
task t_refused;
op(2'h0,1,7'h11,8'hff,8'hff); chk("n0",{acc,zf,zw,fw},{8'h00,3'b100});
@(posedge clk); c<=2'h3; k<=8'hff;
@(posedge clk); #1;
chk("nv",{acc,zf,zw,fw},{8'h00,3'b100});
endtask
task t_reset;
op(2'h3,0,7'h05,0,8'hff);
op(2'h1,1,7'h33,8'h3c,0); chk("pr",{acc,wa,wd},{8'hff,7'h33,8'hc3});
@(posedge clk); rstn<=0;
@(posedge clk); rstn<=1;
#1;
chk("rs",{acc,zf,zw,fw,wa,wd},{8'h00,3'b000,7'h00,8'h00});
endtask
task stop_test;
$display("%0d errors %0d checks",miscompares,checks_done);
if (miscompares==0&&checks_done>0) $display("Regression OK");
else $display("Regression broken");
$finish;
endtask
initial begin
repeat (3) @(posedge clk);
rstn<=1;
#1 chk("po",{acc,zf,zw,fw,wa,wd},{8'h00,3'b000,7'h00,8'h00});
t_swap; t_xor; t_lit; t_refused; t_reset; t_swap; stop_test;
end
endmodule
